// ### logic/kli_cfg.svh
// Offsets, field positions, reset values and timing counts of the keypad level interrupt block
`ifndef KLI_CFG_SVH
`define KLI_CFG_SVH

// ============================================================
// Bus geometry
`define KLI_ADDR_W 10
`define KLI_DATA_W 32
`define KLI_LINES 8

// ============================================================
// Register indices, byte address is four times the index
`define KLI_IDX_LEVEL 8'h9C
`define KLI_IDX_ENABLE 8'h9D
`define KLI_IDX_FLAGS 8'h9E
`define KLI_IDX_GLOBAL 8'hA0
`define KLI_IDX_PINS 8'hA1

// ============================================================
// Field positions
`define KLI_GLOBAL_EN_BIT 0
`define KLI_BYTE0_BIT 0

// ============================================================
// Reset values
`define KLI_RST_LEVEL 8'h00
`define KLI_RST_ENABLE 8'h00
`define KLI_RST_FLAGS 8'h00
`define KLI_RST_GLOBAL 1'h0
`define KLI_RST_RDATA 32'h0000_0000
`define KLI_RST_WAITREQ 1'h1
// Port lines idle high behind their pull-ups
`define KLI_RST_LINE 1'h1

// ============================================================
// Timing counts
`define KLI_SYNC_STAGES 2

`endif

// ### logic/kli_pkg.sv
// Types shared by the keypad level interrupt block
`include "kli_cfg.svh"

package kli_pkg;

    // ============================================================
    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [`KLI_ADDR_W-1:0] address;
        logic [`KLI_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } kli_avm_req_type;

    // ============================================================
    // Avalon-MM answer to the master
    typedef struct packed {
        logic [`KLI_DATA_W-1:0] readdata;
        logic waitrequest;
    } kli_avm_rsp_type;

    // ============================================================
    // Block state
    typedef struct packed {
        logic [`KLI_LINES-1:0] levels;
        logic [`KLI_LINES-1:0] enables;
        logic [`KLI_LINES-1:0] flags;
        logic global_en;
        logic waitreq;
        logic [`KLI_DATA_W-1:0] rdata;
        logic irq;
        logic wake;
        logic [`KLI_LINES-1:0] kbd_mode;
    } kli_state_type;

endpackage

// ### logic/kli_sync.sv
// Two-stage synchroniser for the port one lines
`timescale 1ns/1ps
`include "kli_cfg.svh"

module kli_sync (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Lines
    input wire logic [`KLI_LINES-1:0] i_lines,
    output logic [`KLI_LINES-1:0] o_lines
);

    logic [`KLI_LINES-1:0] meta_q;
    logic [`KLI_LINES-1:0] sync_q;

    // ============================================================
    // Per-line stages
    // Only the second stage is read outside
    genvar g;
    generate
        for (g = 0; g < `KLI_LINES; g = g + 1) begin : g_line
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    // Idle level, so low detect sees no false match after reset
                    meta_q[g] <= `KLI_RST_LINE;
                    sync_q[g] <= `KLI_RST_LINE;
                end else begin
                    meta_q[g] <= i_lines[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_lines = sync_q;

endmodule // kli_sync

// ### logic/kli_top.sv
// Keypad level interrupt block on port one with Avalon-MM register access
//
// Summary of operation
// - Flag register read-only, cleared by read, zero reset
// - Enable zero: standard I/O, no request
// - Request is OR of enabled set flags
// - Select zero detects low line level
// - Select one detects high line level
// - Matching level sets sticky line flag
// - Global enable gates shared keypad request
// - Enabled line event wakes idle processor
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "kli_cfg.svh"

module kli_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register bus
    input wire kli_pkg::kli_avm_req_type i_avm,
    output kli_pkg::kli_avm_rsp_type o_avm,
    // Port one lines from the keypad matrix
    input wire logic [`KLI_LINES-1:0] i_port_one,
    // Per-line pin function, high for keypad use
    output logic [`KLI_LINES-1:0] o_line_kbd_mode,
    // Interrupt and wake
    output logic o_irq,
    output logic o_wake
);

    // ============================================================
    // State and locals
    kli_pkg::kli_state_type st_q;
    kli_pkg::kli_state_type st_d;
    logic [`KLI_LINES-1:0] line_sync;
    logic [`KLI_LINES-1:0] line_match;
    logic [7:0] reg_index;
    logic word_aligned;
    logic hit_level;
    logic hit_enable;
    logic hit_flags;
    logic hit_global;
    logic hit_pins;
    logic req_any;
    logic req_take;
    logic req_ack;
    logic wr_lane0;
    logic rd_clear;
    logic [`KLI_DATA_W-1:0] rd_value;

    // ============================================================
    // Line synchronisers
    kli_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_lines(i_port_one),
        .o_lines(line_sync)
    );

    // ============================================================
    // Per-line level comparison
    genvar g;
    generate
        for (g = 0; g < `KLI_LINES; g = g + 1) begin : g_match
            // Low detect when select is zero, high detect when one
            assign line_match[g] = st_q.levels[g] ? line_sync[g] : ~line_sync[g];
        end
    endgenerate

    // ============================================================
    // Address decode
    assign reg_index = i_avm.address[`KLI_ADDR_W-1:2];
    assign word_aligned = (i_avm.address[1:0] == 2'h0);
    assign hit_level = word_aligned && (reg_index == `KLI_IDX_LEVEL);
    assign hit_enable = word_aligned && (reg_index == `KLI_IDX_ENABLE);
    assign hit_flags = word_aligned && (reg_index == `KLI_IDX_FLAGS);
    assign hit_global = word_aligned && (reg_index == `KLI_IDX_GLOBAL);
    assign hit_pins = word_aligned && (reg_index == `KLI_IDX_PINS);

    // ============================================================
    // Handshake
    // First edge of a request takes it, second edge acknowledges it
    assign req_any = i_avm.read | i_avm.write;
    assign req_take = req_any & st_q.waitreq;
    assign req_ack = req_any & ~st_q.waitreq;
    assign wr_lane0 = req_ack & i_avm.write & i_avm.byteenable[`KLI_BYTE0_BIT];
    // Clear happens when the read is taken, so the value read is the value lost
    assign rd_clear = req_take & i_avm.read & hit_flags;

    // ============================================================
    // Read multiplexer
    always_comb begin
        rd_value = `KLI_RST_RDATA;
        if (hit_level) begin
            rd_value[`KLI_LINES-1:0] = st_q.levels;
        end else if (hit_enable) begin
            rd_value[`KLI_LINES-1:0] = st_q.enables;
        end else if (hit_flags) begin
            rd_value[`KLI_LINES-1:0] = st_q.flags;
        end else if (hit_global) begin
            rd_value[`KLI_GLOBAL_EN_BIT] = st_q.global_en;
        end else if (hit_pins) begin
            rd_value[`KLI_LINES-1:0] = line_sync;
        end
    end

    // ============================================================
    // Next state
    always_comb begin
        st_d = st_q;

        // Bus answer
        st_d.waitreq = ~req_take;
        if (req_take && i_avm.read) begin
            st_d.rdata = rd_value;
        end

        // Writes; flag register ignores writes
        if (wr_lane0 && hit_level) begin
            st_d.levels = i_avm.writedata[`KLI_LINES-1:0];
        end
        if (wr_lane0 && hit_enable) begin
            st_d.enables = i_avm.writedata[`KLI_LINES-1:0];
        end
        if (wr_lane0 && hit_global) begin
            st_d.global_en = i_avm.writedata[`KLI_GLOBAL_EN_BIT];
        end

        // Sticky flags; a match in the clearing cycle wins over the clear
        st_d.flags = (st_q.flags & ~{`KLI_LINES{rd_clear}}) | line_match;

        // Disabled lines stay ordinary port pins
        st_d.kbd_mode = st_d.enables;

        // Shared request through one vector
        st_d.irq = st_d.global_en & (|(st_d.flags & st_d.enables));

        // Wake does not wait on the global enable
        st_d.wake = |(st_d.flags & st_d.enables);
    end

    // ============================================================
    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q.levels <= `KLI_RST_LEVEL;
            st_q.enables <= `KLI_RST_ENABLE;
            st_q.flags <= `KLI_RST_FLAGS;
            st_q.global_en <= `KLI_RST_GLOBAL;
            st_q.waitreq <= `KLI_RST_WAITREQ;
            st_q.rdata <= `KLI_RST_RDATA;
            st_q.irq <= 1'h0;
            st_q.wake <= 1'h0;
            st_q.kbd_mode <= `KLI_RST_ENABLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ============================================================
    // Outputs
    assign o_avm = '{readdata: st_q.rdata, waitrequest: st_q.waitreq};
    assign o_line_kbd_mode = st_q.kbd_mode;
    assign o_irq = st_q.irq;
    assign o_wake = st_q.wake;

endmodule // kli_top

// ### verification/kli_keys.sv
// Keypad matrix model on the port one lines
`timescale 1ns/1ps

module kli_keys (
    // Key presses from the bench
    input wire logic [7:0] i_press,
    // Port one lines
    output logic [7:0] o_lines
);
    // Pull-ups hold open keys high, a closed key grounds its line
    assign o_lines = ~i_press;
endmodule // kli_keys

// ### verification/kli_sva.sv
// Port checks of the keypad level interrupt block
`timescale 1ns/1ps
`include "kli_cfg.svh"

module kli_sva (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register bus
    input wire kli_pkg::kli_avm_req_type i_avm,
    input wire kli_pkg::kli_avm_rsp_type o_avm,
    // Lines and outputs
    input wire logic [`KLI_LINES-1:0] i_port_one,
    input wire logic [`KLI_LINES-1:0] o_line_kbd_mode,
    input wire logic o_irq,
    input wire logic o_wake
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // ============================================================
    // Bus answer
    ack_next_a: assert property ((i_avm.read || i_avm.write) && o_avm.waitrequest |=> !o_avm.waitrequest)
        else $error("ack late");
    ack_one_a: assert property (!o_avm.waitrequest |=> o_avm.waitrequest) else $error("ack too long");
    upper_zero_a: assert property (!o_avm.waitrequest |-> o_avm.readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rdata_hold_a: assert property ($changed(o_avm.readdata) |-> $past(i_avm.read && o_avm.waitrequest))
        else $error("read data moved");
    // ============================================================
    // Request and wake
    irq_gate_a: assert property (o_irq |-> o_wake) else $error("irq without line");
    wake_mode_a: assert property (o_wake |-> |o_line_kbd_mode) else $error("wake masked");
    wake_hold_a: assert property ($fell(o_wake) |-> $past(i_avm.read || i_avm.write))
        else $error("flag lost alone");
    rst_clean_a: assert property ($rose(i_rst_n) |-> !o_irq && o_line_kbd_mode == 8'h0 && o_avm.waitrequest)
        else $error("bad reset state");
endmodule // kli_sva

bind kli_top kli_sva kli_sva_inst (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_avm(i_avm),
    .o_avm(o_avm),
    .i_port_one(i_port_one),
    .o_line_kbd_mode(o_line_kbd_mode),
    .o_irq(o_irq),
    .o_wake(o_wake)
);

// ### verification/tb_top.sv
// Self-checking bench of the keypad level interrupt block
`timescale 1ns/1ps
`include "kli_cfg.svh"

module tb_top;
    logic i_core_clk = 1'h0;
    logic i_rst_n = 1'h0;
    kli_pkg::kli_avm_req_type req = '0;
    kli_pkg::kli_avm_rsp_type rsp;
    logic [7:0] press = 8'h00;
    logic [7:0] pins;
    logic [7:0] mode;
    logic irq;
    logic wake;
    logic [31:0] q;
    int fail_count = 0;
    int total_checks = 0;

    initial forever #12.5 i_core_clk = ~i_core_clk;

    kli_keys kli_keys_inst (.i_press(press), .o_lines(pins));
    kli_top kli_top_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avm(req), .o_avm(rsp),
        .i_port_one(pins), .o_line_kbd_mode(mode), .o_irq(irq), .o_wake(wake));

    // ============================================================
    // Tasks
    task automatic end_sim();
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask

    // Edge first, so a release and a new request never share a time step
    task automatic xfer(logic w, logic [7:0] idx, logic [31:0] d, logic [3:0] be = 4'hF);
        int n;
        n = 0;
        @(posedge i_core_clk);
        req <= '{read: !w, write: w, address: {idx, 2'h0}, writedata: d, byteenable: be};
        do begin
            @(posedge i_core_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        if (n >= 50) begin
            chk("ack timeout", 32'h1, 32'h0);
            end_sim();
        end
    endtask

    task automatic rc(string nm, logic [7:0] idx, logic [31:0] e);
        xfer(1'b0, idx, 32'h0);
        chk(nm, e, q);
    endtask

    // ============================================================
    // Sequence
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rc("level rst", `KLI_IDX_LEVEL, 32'h0);
        rc("enable rst", `KLI_IDX_ENABLE, 32'h0);
        rc("global rst", `KLI_IDX_GLOBAL, 32'h0);
        xfer(1'b0, `KLI_IDX_FLAGS, 32'h0);
        rc("flags clr", `KLI_IDX_FLAGS, 32'h0);
        rc("pins", `KLI_IDX_PINS, 32'hFF);
        xfer(1'b1, `KLI_IDX_FLAGS, 32'hFF);
        rc("flags ro", `KLI_IDX_FLAGS, 32'h0);
        rc("unmapped", 8'h10, 32'h0);
        xfer(1'b1, `KLI_IDX_ENABLE, 32'hFF, 4'hE);
        rc("lane off", `KLI_IDX_ENABLE, 32'h0);
        press <= 8'h08;
        repeat (4) @(posedge i_core_clk);
        press <= 8'h00;
        repeat (4) @(posedge i_core_clk);
        rc("low sticky", `KLI_IDX_FLAGS, 32'h08);
        rc("read clr", `KLI_IDX_FLAGS, 32'h0);
        xfer(1'b1, `KLI_IDX_LEVEL, 32'h01);
        repeat (4) @(posedge i_core_clk);
        rc("high", `KLI_IDX_FLAGS, 32'h01);
        rc("persist", `KLI_IDX_FLAGS, 32'h01);
        xfer(1'b1, `KLI_IDX_LEVEL, 32'h0);
        xfer(1'b0, `KLI_IDX_FLAGS, 32'h0);
        xfer(1'b1, `KLI_IDX_ENABLE, 32'h20);
        xfer(1'b1, `KLI_IDX_GLOBAL, 32'h1);
        press <= 8'h10;
        repeat (4) @(posedge i_core_clk);
        chk("masked irq", 32'h0, 32'(irq));
        press <= 8'h30;
        repeat (4) @(posedge i_core_clk);
        chk("irq", 32'h1, 32'(irq));
        chk("mode", 32'h20, 32'(mode));
        xfer(1'b1, `KLI_IDX_GLOBAL, 32'h0);
        repeat (2) @(posedge i_core_clk);
        chk("gated", 32'h0, 32'(irq));
        chk("wake", 32'h1, 32'(wake));
        press <= 8'h00;
        repeat (4) @(posedge i_core_clk);
        rc("two flags", `KLI_IDX_FLAGS, 32'h30);
        repeat (2) @(posedge i_core_clk);
        chk("wake off", 32'h0, 32'(wake));
        end_sim();
    end
endmodule // tb_top
